/* logic/oss_defines.vh */
// Constants of the octal switch serial control block.
// Assumes a 20 MHz system clock; times are given in microseconds.
`ifndef OSS_DEFINES_VH
`define OSS_DEFINES_VH

`define OSS_CLK_MHZ          20
`define OSS_WORD_BITS        16
`define OSS_NUM_OUT          8
`define OSS_CMD_OUT_LSB      0
`define OSS_CMD_OLD_LSB      8
`define OSS_STATUS_PAD       8'h00
`define OSS_CMD_RESET        16'h0000
`define OSS_FAULT_MIN_US     100
`define OSS_FAULT_MAX_US     300
`define OSS_POR_US           100
// Qualify time: at least the minimum, well below the maximum
`define OSS_FAULT_CYCLES     (`OSS_FAULT_MIN_US * `OSS_CLK_MHZ)
`define OSS_POR_CYCLES       (`OSS_POR_US * `OSS_CLK_MHZ)
`define OSS_CNT_W            13

`endif

/* logic/oss_fault_qual.v */
// One fault qualifier per output: a raw fault must persist before it counts.
// Assumes rawFault is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "oss_defines.vh"

module oss_fault_qual #(
    parameter [12:0] QUAL_CYCLES = `OSS_FAULT_CYCLES
) (
    input  wire clk,
    input  wire rst_n,
    input  wire clear,
    input  wire rawFault,
    output reg  qualified
);

    reg [12:0] count;

    always @(posedge clk) begin
        if (!rst_n || clear || !rawFault) begin
            count     <= 13'h0000;
            qualified <= 1'b0;
        end else if (count >= QUAL_CYCLES - 13'h0001) begin
            qualified <= 1'b1;                         // see R19
        end else begin
            count <= count + 13'h0001;
        end
    end

endmodule
`default_nettype wire

/* logic/oss_serial_switch.v */
// Control logic of an eight-output switch behind a 16-bit serial link.
// Assumes link pins arrive asynchronously and are sampled by clk (20 MHz);
// serial clock up to about 2.5 MHz so each edge is seen.
//
// Contract
// R01: Selected: status driver enabled, command shifted in, status shifted out.
// R02: Command word applied only on chip select rising edge.
// R03: Command input sampled on each serial clock falling edge.
// R04: Next status bit driven on each serial clock rising edge.
// R05: Deselected: clock and data ignored, status output released.
// R06: Host keeps serial clock low whenever chip select changes.
// R07: Host parks serial clock low while deselected.
// R08: Command bit one turns output on, zero turns it off.
// R09: Host sends detect-current bits first, then outputs eight down to one.
// R10: A transfer shifts sixteen bits, one per falling edge.
// R11: Status bit one means open or shorted load, zero normal.
// R12: Off output with detect current disabled reports zero.
// R13: Status word: eight zeros then eight fault bits, MSB first.
// R14: Enable low: outputs off, detect current off, sleep.
// R15: Enable high: outputs driven, fault detection runs and reports.
// R16: Power-on reset on enable rising edge.
// R17: Host waits 100 us after enable before any transfer.
// R18: Reset needs enable low for at least 100 us.
// R19: Fault bit set after fault persists between 100 and 300 us.
// R20: Host leaves over 300 us between accesses to read faults.
// R21: Outputs five and six are command bit OR direct input.
// R22: Host keeps serial bit zero for direct drive, and vice versa.
// R23: Host toggles direct inputs no faster than 2 kHz.
// R24: Bits 0-7 switch outputs one-eight; bits 8-15 enable detect current.
// R25: Status bits 8-15 read zero, bits 0-7 carry output faults.
// R26: After power-on reset the applied command is cleared.
`timescale 1ns/1ps
`default_nettype none
`include "oss_defines.vh"

module oss_serial_switch (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       chipSelect_n,
    input  wire       serialClock,
    input  wire       serial_command_input,
    output reg        statusOut,
    output reg        statusOutEn,
    input  wire       enable,
    input  wire       direct_pwm_input_five,
    input  wire       direct_pwm_input_six,
    input  wire [7:0] loadFault,
    output reg  [7:0] outputOn,
    output reg  [7:0] openLoadCurrentOn,
    output reg        sleepMode,
    output reg        linkReady
);

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; stage one is read only by stage two
    reg [5:0]  syncA;
    reg [5:0]  syncB;
    reg [7:0]  faultA;
    reg [7:0]  faultB;
    reg        sclkPrev;
    reg        csPrev;
    reg        enPrev;

    always @(posedge clk) begin
        if (!rst_n) begin
            syncA  <= 6'h01;
            syncB  <= 6'h01;
            faultA <= 8'h00;
            faultB <= 8'h00;
        end else begin
            syncA  <= {direct_pwm_input_six, direct_pwm_input_five, enable,
                       serial_command_input, serialClock, chipSelect_n};
            syncB  <= syncA;
            faultA <= loadFault;
            faultB <= faultA;
        end
    end

    wire csN   = syncB[0];
    wire sclk  = syncB[1];
    wire din   = syncB[2];
    wire en    = syncB[3];
    wire pwm5  = syncB[4];
    wire pwm6  = syncB[5];

    wire sclkRise = sclk & ~sclkPrev;
    wire sclkFall = ~sclk & sclkPrev;
    wire csRise   = csN & ~csPrev;
    wire csFall   = ~csN & csPrev;
    wire enRise   = en & ~enPrev;

    always @(posedge clk) begin
        if (!rst_n) begin
            sclkPrev <= 1'b0;
            csPrev   <= 1'b1;
            enPrev   <= 1'b0;
        end else begin
            sclkPrev <= sclk;
            csPrev   <= csN;
            enPrev   <= en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset timer started by enable rising edge
    // The timer load is cut to the counter width on purpose
    localparam [31:0] POR_FULL = `OSS_POR_CYCLES;

    reg [12:0] porCount;
    wire       porActive = (porCount != 13'h0000);

    always @(posedge clk) begin
        if (!rst_n) begin
            porCount <= 13'h0000;
        end else if (enRise) begin
            porCount <= POR_FULL[12:0];                  // see R16
        end else if (porActive) begin
            porCount <= porCount - 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame tracking: a frame counts only if it opened while the link was
    // live, so a select that falls inside the power-on wait never applies
    localparam [1:0] FR_IDLE  = 2'b00;
    localparam [1:0] FR_SHIFT = 2'b01;
    localparam [1:0] FR_APPLY = 2'b10;

    reg [1:0]  frameState;
    reg [1:0]  next_frameState;
    reg [15:0] shiftIn;
    reg [15:0] next_shiftIn;
    reg [15:0] shiftOut;
    reg [15:0] next_shiftOut;
    reg [15:0] applied;
    reg [15:0] next_applied;
    reg [4:0]  bitCount;
    reg [4:0]  next_bitCount;
    wire [7:0] qualFault;
    wire [7:0] rawFault;
    // The enable edge itself already holds the link, one cycle before the
    // timer loads; otherwise ready would blink high for a cycle
    wire       linkHeld = ~en | enRise | porActive;

    ////////////////////////////////////////////////////////////////////////
    // Fault qualification per output
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : gQual
            // Off and undetected outputs cannot show a fault
            assign rawFault[i] = en & faultB[i] &
                (applied[i] | applied[i + 8]);           // see R12, R15
            oss_fault_qual uQual (
                .clk       (clk),
                .rst_n     (rst_n),
                .clear     (porActive),
                .rawFault  (rawFault[i]),
                .qualified (qualFault[i])                // see R11
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Shift registers and applied command
    always @* begin
        next_frameState = frameState;
        next_shiftIn    = shiftIn;
        next_shiftOut   = shiftOut;
        next_applied    = applied;
        next_bitCount   = bitCount;
        if (linkHeld) begin
            // Whatever is on the link now is dropped
            next_frameState = FR_IDLE;
            next_applied    = `OSS_CMD_RESET;            // see R14, R26
            next_bitCount   = 5'h00;
        end else begin
            case (frameState)
            FR_IDLE: begin
                if (csFall) begin
                    // Status is frozen here, zero pad then faults
                    next_shiftOut = {`OSS_STATUS_PAD, qualFault}; // see R13
                    next_bitCount   = 5'h00;
                    next_frameState = FR_SHIFT;
                end
            end
            FR_SHIFT: begin
                if (csN) begin
                    next_frameState = FR_APPLY;          // see R05
                end else begin
                    if (sclkFall) begin
                        next_shiftIn = {shiftIn[14:0], din}; // see R03, R10
                        if (bitCount != 5'h10) begin
                            next_bitCount = bitCount + 5'h01;
                        end
                    end
                    if (sclkRise && bitCount != 5'h00) begin
                        // First bit is already on the pin from select
                        next_shiftOut = {shiftOut[14:0], 1'b0}; // see R04
                    end
                end
            end
            FR_APPLY: begin
                next_applied    = shiftIn;               // see R02, R08, R24
                next_frameState = FR_IDLE;
            end
            default: begin
                next_frameState = FR_IDLE;
            end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            frameState <= FR_IDLE;
            shiftIn    <= 16'h0000;
            shiftOut   <= 16'h0000;
            applied    <= `OSS_CMD_RESET;
            bitCount   <= 5'h00;
        end else begin
            frameState <= next_frameState;
            shiftIn    <= next_shiftIn;
            shiftOut   <= next_shiftOut;
            applied    <= next_applied;
            bitCount   <= next_bitCount;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-output drive: outputs five and six also take their direct input
    wire [7:0] directDrive = {2'b00, pwm6, pwm5, 4'h0};
    wire [7:0] driveWant;
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : gDrive
            assign driveWant[k] = en & (applied[k] | directDrive[k]); // see R21
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            statusOut   <= 1'b0;
            statusOutEn <= 1'b0;
        end else begin
            statusOutEn <= ~csN;                         // see R01, R05
            statusOut   <= shiftOut[15];                 // see R13, R25
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            outputOn          <= 8'h00;
            openLoadCurrentOn <= 8'h00;
        end else begin
            outputOn          <= driveWant;              // see R08, R14
            openLoadCurrentOn <= en ? applied[15:8] : 8'h00; // see R24
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            sleepMode <= 1'b1;
            linkReady <= 1'b0;
        end else begin
            sleepMode <= ~en;                            // see R14
            linkReady <= ~linkHeld;                      // see R16
        end
    end

endmodule
`default_nettype wire

/* testbench/oss_asserts.sv */
// Port checker for the serial switch.
// Assumes the 20 MHz clk and synchronous rst_n of the switch.
`timescale 1ns/1ps
`default_nettype none
module oss_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       chipSelect_n,
    input wire logic       serialClock,
    input wire logic       statusOut,
    input wire logic       statusOutEn,
    input wire logic       enable,
    input wire logic       direct_pwm_input_five,
    input wire logic       direct_pwm_input_six,
    input wire logic [7:0] outputOn,
    input wire logic [7:0] openLoadCurrentOn,
    input wire logic       sleepMode,
    input wire logic       linkReady
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Repeat counts cover the two-flop input synchronisers
    AST_SLEEP: assert property (
        (!enable)[*4] |-> sleepMode && outputOn == 8'h00
        && openLoadCurrentOn == 8'h00) else $error("sleep not quiet");
    AST_DESEL: assert property (
        chipSelect_n[*5] |-> !statusOutEn) else $error("status driven");
    AST_SEL: assert property (
        (!chipSelect_n && linkReady)[*5] |-> statusOutEn)
        else $error("status not driven");
    AST_HOLD: assert property (
        (!chipSelect_n && enable)[*8] |=> $stable(outputOn & 8'hcf)
        && $stable(openLoadCurrentOn)) else $error("early apply");
    AST_PWM5: assert property (
        (enable && linkReady && direct_pwm_input_five)[*5] |-> outputOn[4])
        else $error("direct five ignored");
    AST_PWM6: assert property (
        (enable && linkReady && direct_pwm_input_six)[*5] |-> outputOn[5])
        else $error("direct six ignored");
    AST_POR: assert property (
        $rose(enable) |=> (!linkReady)[*8]) else $error("no power-on wait");
    AST_CLEAR: assert property (
        $rose(linkReady) |-> (outputOn & 8'hcf) == 8'h00
        && openLoadCurrentOn == 8'h00) else $error("command not cleared");
    AST_SHIFT: assert property (
        (!chipSelect_n && $stable(serialClock))[*8] |=> $stable(statusOut))
        else $error("status moved without clock");
    cover property ($rose(chipSelect_n) && linkReady);
    cover property ($rose(linkReady));
    cover property (outputOn[4] && direct_pwm_input_five);
endmodule
bind oss_serial_switch oss_asserts chk_u (.*);
`default_nettype wire

/* testbench/oss_host_model.sv */
// Host side of the link: master that shifts one 16-bit word.
// Assumes a 400 ns serial clock period, edges on clk falling edges.
`timescale 1ns/1ps
`default_nettype none
module oss_host_model (
    input  wire logic clk,
    input  wire logic statusOut,
    output var  logic chipSelect_n,
    output var  logic serialClock,
    output var  logic serial_command_input
);
    initial begin
        chipSelect_n = 1'b1;
        serialClock = 1'b0;
        serial_command_input = 1'b0;
    end
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] sts);
        integer i;
        @(negedge clk);
        chipSelect_n = 1'b0;
        #400;
        for (i = 15; i >= 0; i--) begin
            serialClock = 1'b1;
            serial_command_input = cmd[i];
            #200;
            serialClock = 1'b0;
            // Mid low phase leaves margin for the sampled status path
            #100;
            sts[i] = statusOut;
            #100;
        end
        chipSelect_n = 1'b1;
        #200;
        serial_command_input = ~serial_command_input;
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the serial switch with a host model.
// Assumes 20 MHz clk; inputs change on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin testsRun++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, enable = 1'b0;
    logic direct_pwm_input_five = 1'b0, direct_pwm_input_six = 1'b0;
    logic [7:0] loadFault = 8'h00;
    logic [15:0] sts;
    wire cs, sclk, di, statusOut, soe, sleepMode, linkReady;
    wire [7:0] outputOn, olc;
    integer failures = 0, testsRun = 0, cycles = 0;
    always #25 clk = ~clk;
    oss_host_model host_u (.clk(clk), .statusOut(statusOut),
        .chipSelect_n(cs), .serialClock(sclk), .serial_command_input(di));
    oss_serial_switch dut_u (.clk(clk), .rst_n(rst_n), .chipSelect_n(cs),
        .serialClock(sclk), .serial_command_input(di),
        .statusOut(statusOut), .statusOutEn(soe), .enable(enable),
        .direct_pwm_input_five(direct_pwm_input_five),
        .direct_pwm_input_six(direct_pwm_input_six), .loadFault(loadFault),
        .outputOn(outputOn), .openLoadCurrentOn(olc),
        .sleepMode(sleepMode), .linkReady(linkReady));
    task automatic wait_ready;
        integer n;
        n = 0;
        while (linkReady !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        `CHK("linkReady", 1'b1, linkReady)
    endtask
    task automatic send(input logic [15:0] cmd);
        host_u.xfer(cmd, sts);
        repeat (10) @(negedge clk);
    endtask
    task automatic t_cmd;
        send(16'h3c5a);
        `CHK("outputOn", 8'h5a, outputOn)
        send(16'h3ca5);
        `CHK("outputOn", 8'ha5, outputOn)
        `CHK("detect", 8'h3c, olc)
        `CHK("status", 16'h0000, sts)
        `CHK("statusOutEn", 1'b0, soe)
        $display("t_cmd done");
    endtask
    task automatic t_fault;
        loadFault = 8'h83;
        send(16'h3ca5);
        `CHK("status", 16'h0000, sts)
        // Longer than the slowest qualify time before reading back
        repeat (6200) @(negedge clk);
        send(16'h3ca5);
        `CHK("status", 16'h0081, sts)
        loadFault = 8'h00;
        $display("t_fault done");
    endtask
    task automatic t_pwm;
        send(16'h0000);
        direct_pwm_input_five = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("outputOn", 8'h10, outputOn)
        repeat (4992) @(negedge clk);
        direct_pwm_input_five = 1'b0;
        direct_pwm_input_six = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("outputOn", 8'h20, outputOn)
        repeat (4992) @(negedge clk);
        direct_pwm_input_six = 1'b0;
        $display("t_pwm done");
    endtask
    task automatic t_sleep;
        send(16'hffff);
        enable = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("outputOn", 8'h00, outputOn)
        `CHK("sleepMode", 1'b1, sleepMode)
        repeat (2000) @(negedge clk);
        enable = 1'b1;
        repeat (10) @(negedge clk);
        `CHK("linkReady", 1'b0, linkReady)
        wait_ready;
        `CHK("detect", 8'h00, olc)
        $display("t_sleep done");
    endtask
    task close_out;
        $display("checks %0d failures %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            close_out;
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        enable = 1'b1;
        wait_ready;
        t_cmd;
        t_fault;
        t_pwm;
        t_sleep;
        close_out;
    end
endmodule
`default_nettype wire
